// [framer_pkg.sv]
// Shared constants and carrier types for the remote message framer
package framer_pkg;

  localparam int unsigned CLK_FREQ_HZ        = 200_000_000;
  localparam int unsigned BYTE_TIMEOUT_US    = 5_000;
  localparam int unsigned IDLE_TIMEOUT_MS    = 5_000;
  localparam longint unsigned BYTE_TIMEOUT_CYC =
    longint'(BYTE_TIMEOUT_US) * CLK_FREQ_HZ / 1_000_000;
  localparam longint unsigned IDLE_TIMEOUT_CYC =
    longint'(IDLE_TIMEOUT_MS) * CLK_FREQ_HZ / 1_000;

  localparam logic [7:0]  CHAR_LF         = 8'h0A;
  localparam logic [7:0]  CHAR_CR         = 8'h0D;
  localparam logic [7:0]  MODBUS_ADDR     = 8'h00;
  localparam logic [7:0]  FIRST_TEXT_CODE = 8'h2A;
  localparam logic [15:0] FULL_SCALE_CODE = 16'hCCCC;
  localparam logic [15:0] MAX_SET_CODE    = 16'hD0E5;
  localparam logic [15:0] EFFECTIVE_STEPS = 16'h6666;
  localparam int unsigned FIFO_DEPTH      = 32;
  localparam int unsigned ERR_CNT_W       = 8;

  typedef enum logic [1:0] {
    PROTO_MODBUS = 2'b00,
    PROTO_BADADR = 2'b01,
    PROTO_TEXT   = 2'b10,
    PROTO_TCP    = 2'b11
  } proto_type;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
  } byte_type;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] lo_limit;
    logic [15:0] hi_limit;
  } setval_type;

endpackage

// [byte_fifo.sv]
// Synchronous valid/ready FIFO for received message bytes
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Handshakes drop while frozen so no word is lost or doubled
  assign in_ready  = clk_en && (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = clk_en && (cnt_q != '0);
  assign out_data  = mem[rd_q];

  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [remote_message_framer.sv]
// Receive framing, protocol sorting, idle drop and set-value checks
`timescale 1ns/1ps
`default_nettype none
// Contract
// - A message closes when the inter-byte timeout runs out after its last byte.
// - The inter-byte timeout is a setting loaded by local setup or remote command.
// - LF, CR or CRLF on text messages closes the message at once.
// - Unterminated messages are released only after the inter-byte timeout expires.
// - Socket links are closed after a settable period with no traffic.
// - After an idle close a new connection is accepted at any time.
// - Set values outside the user limits are rejected with an error.
// - Text-protocol rejection errors are queued and reported only on request.
// - All quantities use codes 0 to 0xCCCC for zero to full rating.
// - Effective steps follow the 15-bit converter: 26214 steps full scale.
// - Serial and socket links take ModBus RTU and text; TCP port adds ModBus TCP. The code classes every TCP port byte as ModBus TCP, with no text framing.
// - First byte zero is ModBus, 1 to 41 an error, 42 upward text.
// - Set codes 0x0000 to 0xD0E5 accepted, larger codes rejected.
module remote_message_framer
  import framer_pkg::*;
#(
  parameter longint unsigned BYTE_TIMEOUT_DEF = BYTE_TIMEOUT_CYC,
  parameter longint unsigned IDLE_TIMEOUT_DEF = IDLE_TIMEOUT_CYC,
  parameter int unsigned     TMR_W            = 32,
  parameter int unsigned     DEPTH            = FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [7:0]       rx_data,
  input  wire logic             rx_valid,
  output logic                  rx_ready,
  input  wire logic             tcp_port_sel,
  input  wire logic             tmo_load,
  input  wire logic [TMR_W-1:0] tmo_value,
  input  wire logic             idle_load,
  input  wire logic [TMR_W-1:0] idle_value,
  input  wire logic             conn_req,
  output logic                  conn_open,
  output logic                  conn_closed_idle,
  output byte_type              msg_byte,
  output logic                  msg_valid,
  input  wire logic             msg_ready,
  output proto_type             msg_proto,
  output logic                  proto_error,
  input  wire logic             set_check,
  input  wire setval_type       set_in,
  output logic                  set_accept,
  output logic                  set_reject,
  input  wire logic             err_read,
  output logic [ERR_CNT_W-1:0]  err_pending,
  output logic [15:0]           eff_step
);
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_COLLECT = 2'b01,
    ST_CR_SEEN = 2'b10
  } state_type;

  state_type            state_q;
  state_type            state_d;
  logic [TMR_W-1:0]     tmo_q;
  logic [TMR_W-1:0]     idle_lim_q;
  logic [TMR_W-1:0]     gap_q;
  logic [TMR_W-1:0]     idle_q;
  logic                 pend_q;
  logic [7:0]           pend_data_q;
  logic                 pend_first_q;
  logic                 text_q;
  proto_type            proto_q;
  logic [ERR_CNT_W-1:0] err_q;
  logic                 conn_q;
  logic                 closed_q;
  logic                 acc_q;
  logic                 rej_q;
  logic                 perr_q;

  function automatic proto_type classify(input logic [7:0] b, input logic tcp);
    if (tcp) begin
      return PROTO_TCP;
    end else if (b == MODBUS_ADDR) begin
      return PROTO_MODBUS;
    end else if (b < FIRST_TEXT_CODE) begin
      return PROTO_BADADR;
    end
    return PROTO_TEXT;
  endfunction

  function automatic logic is_term(input logic [7:0] b);
    return (b == CHAR_LF) || (b == CHAR_CR);
  endfunction

  // One byte is held back so its last flag is known before it enters the FIFO
  wire       fifo_in_ready;
  wire       take      = rx_valid && rx_ready;
  // A byte after a closing CR opens the next message unless it is a terminator
  wire       first_b   = (state_q == ST_IDLE)
                      || (state_q == ST_CR_SEEN && !is_term(rx_data));
  wire proto_type cls  = classify(rx_data, tcp_port_sel);
  wire       text_now  = first_b ? (cls == PROTO_TEXT) : text_q;
  wire       term_b    = take && text_now && is_term(rx_data);
  // Close waits for FIFO room so the held byte is never dropped
  wire       gap_done  = (state_q != ST_IDLE) && (gap_q >= tmo_q)
                      && (!pend_q || fifo_in_ready);
  wire       lf_after_cr = take && (state_q == ST_CR_SEEN) && (rx_data == CHAR_LF);
  wire       flush     = pend_q && (gap_done || (term_b && !lf_after_cr));
  wire       push      = pend_q && (take || gap_done);
  wire       push_last = flush || (gap_done && pend_q);

  // Back-pressure stalls reception while the held byte cannot move on
  assign rx_ready = clk_en && conn_q && (!pend_q || fifo_in_ready) && !gap_done;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = term_b ? ST_CR_SEEN : ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (gap_done) begin
          state_d = ST_IDLE;
        end else if (term_b) begin
          state_d = (rx_data == CHAR_CR) ? ST_CR_SEEN : ST_IDLE;
        end
      end
      ST_CR_SEEN: begin
        if (gap_done || lf_after_cr) begin
          state_d = ST_IDLE;
        end else if (take && !term_b) begin
          state_d = ST_COLLECT;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  byte_type fifo_in;
  assign fifo_in = '{data: pend_data_q, first: pend_first_q, last: push_last};

  byte_fifo #(
    .WIDTH ($bits(byte_type)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_data   (fifo_in),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (msg_byte),
    .out_valid (msg_valid),
    .out_ready (msg_ready)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      pend_q       <= 1'b0;
      pend_data_q  <= 8'h00;
      pend_first_q <= 1'b0;
      text_q       <= 1'b0;
      proto_q      <= PROTO_MODBUS;
      perr_q       <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      perr_q  <= 1'b0;
      if (take && first_b) begin
        text_q  <= (cls == PROTO_TEXT);
        proto_q <= cls;
        perr_q  <= (cls == PROTO_BADADR);
      end
      // Terminators are consumed; the byte before them is the last one
      if (take && !term_b && !lf_after_cr) begin
        pend_q       <= 1'b1;
        pend_data_q  <= rx_data;
        pend_first_q <= first_b;
      end else if (push || flush) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Timer restarts on every byte and idles between messages
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gap_q <= '0;
    end else if (clk_en) begin
      if (take || state_q == ST_IDLE) begin
        gap_q <= '0;
      end else if (gap_q < tmo_q) begin
        gap_q <= gap_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tmo_q      <= TMR_W'(BYTE_TIMEOUT_DEF);
      idle_lim_q <= TMR_W'(IDLE_TIMEOUT_DEF);
    end else if (clk_en) begin
      if (tmo_load) begin
        tmo_q <= (tmo_value == '0) ? TMR_W'(1) : tmo_value;
      end
      if (idle_load) begin
        idle_lim_q <= (idle_value == '0) ? TMR_W'(1) : idle_value;
      end
    end
  end

  // Idle drop of the socket, reopened by any later request
  wire traffic = take || (msg_valid && msg_ready);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conn_q   <= 1'b0;
      closed_q <= 1'b0;
      idle_q   <= '0;
    end else if (clk_en) begin
      closed_q <= 1'b0;
      if (!conn_q) begin
        idle_q <= '0;
        if (conn_req) begin
          conn_q <= 1'b1;
        end
      end else if (traffic) begin
        idle_q <= '0;
      end else if (idle_q >= idle_lim_q - 1'b1) begin
        conn_q   <= 1'b0;
        closed_q <= 1'b1;
      end else begin
        idle_q <= idle_q + 1'b1;
      end
    end
  end

  // Set-value check against code ceiling and user limits
  wire in_range = (set_in.value <= MAX_SET_CODE)
               && (set_in.value >= set_in.lo_limit)
               && (set_in.value <= set_in.hi_limit);
  wire reject   = set_check && !in_range;
  wire queue_e  = reject && text_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q <= 1'b0;
      rej_q <= 1'b0;
      err_q <= '0;
    end else if (clk_en) begin
      acc_q <= set_check && in_range;
      rej_q <= reject && !text_q;
      // A new error in the same cycle as a read is kept
      if (queue_e && !(err_read && err_q != '0)) begin
        err_q <= (err_q == '1) ? err_q : err_q + 1'b1;
      end else if (!queue_e && err_read && err_q != '0) begin
        err_q <= err_q - 1'b1;
      end
    end
  end

  assign conn_open        = conn_q;
  assign conn_closed_idle = closed_q;
  assign msg_proto        = proto_q;
  assign proto_error      = perr_q;
  assign set_accept       = acc_q;
  assign set_reject       = rej_q;
  assign err_pending      = err_q;
  assign eff_step         = EFFECTIVE_STEPS;
endmodule
`default_nettype wire

// [framer_monitor.sv]
// Port checks for the remote message framer
`timescale 1ns/1ps
`default_nettype none
module framer_monitor
  import framer_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic [7:0]           rx_data,
  input wire logic                 rx_valid,
  input wire logic                 rx_ready,
  input wire logic                 conn_open,
  input wire logic                 conn_closed_idle,
  input wire logic                 msg_valid,
  input wire proto_type            msg_proto,
  input wire logic                 proto_error,
  input wire logic                 set_check,
  input wire setval_type           set_in,
  input wire logic                 set_accept,
  input wire logic                 set_reject,
  input wire logic                 err_read,
  input wire logic [ERR_CNT_W-1:0] err_pending,
  input wire logic [15:0]          eff_step
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire in_lim = set_in.value <= MAX_SET_CODE && set_in.lo_limit <= set_in.value
    && set_in.value <= set_in.hi_limit;
  wire data_take = rx_valid && rx_ready && rx_data != CHAR_CR && rx_data != CHAR_LF;
  sequence take_s; data_take; endsequence
  sequence quiet_s; !(rx_valid && rx_ready) [*8]; endsequence
  // Bad address frames may be discarded, so the class stands in for output
  msg_close_a: assert property (take_s ##1 quiet_s |-> ##[1:40]
    (msg_valid || msg_proto == PROTO_BADADR)) else $error("message not closed");
  step_const_a: assert property (eff_step == EFFECTIVE_STEPS)
    else $error("step count wrong");
  set_ok_a: assert property (set_check && in_lim |=> set_accept && !set_reject)
    else $error("in range value refused");
  code_max_a: assert property (set_check && set_in.value > MAX_SET_CODE |=> !set_accept)
    else $error("over range code accepted");
  set_cause_a: assert property (set_accept || set_reject |-> $past(set_check))
    else $error("set answer without check");
  bad_addr_a: assert property (proto_error |-> msg_proto == PROTO_BADADR)
    else $error("error without bad class");
  idle_drop_a: assert property (conn_closed_idle |-> !conn_open)
    else $error("open after idle drop");
  closed_ready_a: assert property (!conn_open |-> !rx_ready)
    else $error("ready while closed");
  err_queue_a: assert property (err_pending > $past(err_pending) |-> $past(set_check))
    else $error("error queued spontaneously");
  err_take_a: assert property (err_read && !set_check && err_pending != 0
    |=> err_pending == $past(err_pending) - 1) else $error("queued error not taken");
endmodule
bind remote_message_framer framer_monitor MON (.ref_clk, .rst_n, .rx_data, .rx_valid,
  .rx_ready, .conn_open, .conn_closed_idle, .msg_valid, .msg_proto, .proto_error,
  .set_check, .set_in, .set_accept, .set_reject, .err_read, .err_pending, .eff_step);
`default_nettype wire

// [host_model.sv]
// Host byte source facing the framer link input
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic ref_clk,
  input  wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic       rx_valid
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // Released line shows the inverse so a stale byte cannot pass
  task automatic send(input logic [7:0] b, input bit h, input int lim, output logic ok);
    int n;
    n = 0;
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    while (!rx_ready && n < lim) begin
      n++;
      @(posedge ref_clk);
    end
    ok = rx_ready;
    if (!h || !ok) begin
      rx_valid <= 1'b0;
      rx_data <= ~b;
    end
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the remote message framer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import framer_pkg::*;
  logic ref_clk = 0, rst_n = 0, clk_en = 1, tcp_port_sel = 0, conn_req = 0;
  logic tmo_load = 0, idle_load = 0, msg_ready = 0, set_check = 0, err_read = 0;
  logic [31:0] tmo_value = 0, idle_value = 0;
  logic [7:0] rx_data, err_pending;
  logic rx_valid, rx_ready, conn_open, conn_closed_idle, msg_valid;
  logic proto_error, set_accept, set_reject;
  logic [15:0] eff_step;
  byte_type msg_byte;
  byte_type got [64];
  proto_type msg_proto;
  setval_type set_in = '0;
  int errors = 0, compares = 0;
  always #2.5 ref_clk = ~ref_clk;
  remote_message_framer #(.BYTE_TIMEOUT_DEF(20), .IDLE_TIMEOUT_DEF(50)) DUT (.ref_clk,
    .rst_n, .clk_en, .rx_data, .rx_valid, .rx_ready, .tcp_port_sel, .tmo_load,
    .tmo_value, .idle_load, .idle_value, .conn_req, .conn_open, .conn_closed_idle,
    .msg_byte, .msg_valid, .msg_ready, .msg_proto, .proto_error, .set_check, .set_in,
    .set_accept, .set_reject, .err_read, .err_pending, .eff_step);
  host_model HOST (.ref_clk, .rx_ready, .rx_data, .rx_valid);
  task automatic end_sim();
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tx(input logic [7:0] b, input bit h);
    logic ok;
    HOST.send(b, h, 60, ok);
    if (!ok) tmo("byte send");
  endtask
  task automatic tmo(input string nm);
    errors++;
    $display("[FAIL] %s expected done seen timeout", nm);
    end_sim();
  endtask
  task automatic wt(input int k, input int lim, output int c);
    c = 0;
    while ((k == 1 ? conn_open : conn_closed_idle) !== 1'b1) begin
      if (c == lim) tmo("wait level");
      c++;
      @(posedge ref_clk);
    end
  endtask
  task automatic rx_msg(input int lim, output int n, output int c);
    n = 0;
    msg_ready <= 1;
    for (c = 1; c <= lim; c++) begin
      @(posedge ref_clk);
      if (msg_valid && msg_ready) begin
        got[n] = msg_byte;
        n++;
        if (msg_byte.last) begin msg_ready <= 0; return; end
      end
    end
    tmo("message close");
  endtask
  task automatic ld(input int v);
    tmo_value <= v;
    tmo_load <= 1;
    @(posedge ref_clk);
    tmo_load <= 0;
  endtask
  task automatic t_term();
    logic [7:0] tm [3] = '{8'h0D, 8'h0A, 8'h0D};
    int n, c;
    for (int k = 0; k < 3; k++) begin
      tx(8'h2A, 1);
      tx(8'h41, 1);
      tx(tm[k], k == 2);
      if (k == 2) tx(8'h0A, 0);
      rx_msg(12, n, c);
      chk("term len", 2, n);
      chk("byte0", {8'h2A, 2'b10}, got[0]);
      chk("byte1", {8'h41, 2'b01}, got[1]);
      chk("text class", PROTO_TEXT, msg_proto);
    end
  endtask
  task automatic t_gap();
    int n, c;
    tx(8'h00, 0);
    repeat (15) @(posedge ref_clk);
    tx(8'h03, 0);
    repeat (15) @(posedge ref_clk);
    tx(8'h07, 0);
    // Frozen cycles must not count toward the gap
    clk_en <= 0;
    repeat (10) @(posedge ref_clk);
    clk_en <= 1;
    rx_msg(40, n, c);
    chk("close gap", 1, c >= 19 && c <= 26);
    chk("gap len", 3, n);
    chk("modbus class", PROTO_MODBUS, msg_proto);
  endtask
  task automatic sc(input logic [15:0] v, lo, hi, input bit a, r);
    set_in <= '{v, lo, hi};
    set_check <= 1;
    @(posedge ref_clk);
    set_check <= 0;
    @(posedge ref_clk);
    chk("accept", a, set_accept);
    chk("reject", r, set_reject);
  endtask
  task automatic t_set();
    int n, c;
    sc(16'hCCCC, 16'h0000, 16'hFFFF, 1, 0);
    sc(16'hD0E5, 16'h0000, 16'hFFFF, 1, 0);
    sc(16'hD0E6, 16'h0000, 16'hFFFF, 0, 1);
    sc(16'h2000, 16'h2000, 16'h2000, 1, 0);
    sc(16'h1FFF, 16'h2000, 16'hFFFF, 0, 1);
    tx(8'h2A, 1);
    tx(8'h0A, 0);
    rx_msg(12, n, c);
    sc(16'h3000, 16'h0000, 16'h2FFF, 0, 0);
    chk("queued", 1, err_pending);
    err_read <= 1;
    @(posedge ref_clk);
    err_read <= 0;
    @(posedge ref_clk);
    chk("dequeued", 0, err_pending);
  endtask
  task automatic t_bad();
    logic [7:0] b [2] = '{8'h01, 8'h29};
    for (int k = 0; k < 2; k++) begin
      tx(b[k], 0);
      @(posedge ref_clk);
      chk("proto error", 1, proto_error);
      chk("bad class", PROTO_BADADR, msg_proto);
      msg_ready <= 1;
      repeat (25) @(posedge ref_clk);
      msg_ready <= 0;
    end
  endtask
  task automatic t_fill();
    logic ok;
    int s, p;
    s = 0;
    ok = 1;
    tcp_port_sel <= 1;
    while (ok && s < 40) begin
      HOST.send(8'h41 + s[7:0], 1, 2, ok);
      if (ok) s++;
    end
    chk("refused", FIFO_DEPTH + 1, s);
    // Stall every other cycle while draining
    p = 0;
    // Short enough that the idle drop cannot close the link afterwards
    for (int c = 0; c < 80; c++) begin
      @(posedge ref_clk);
      if (msg_valid && msg_ready) begin
        chk("fill byte", {8'h41 + p[7:0], p == 0, p == s - 1}, msg_byte);
        p++;
      end
      msg_ready <= !c[0];
    end
    tcp_port_sel <= 0;
    chk("drained", s, p);
    chk("tcp class", PROTO_TCP, msg_proto);
    chk("empty", 0, msg_valid);
  endtask
  initial begin
    int n, c;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    conn_req <= 1;
    wt(1, 10, c);
    conn_req <= 0;
    t_term();
    t_gap();
    t_set();
    t_bad();
    t_fill();
    ld(40);
    tx(8'h00, 0);
    rx_msg(60, n, c);
    chk("loaded gap", 1, c >= 39 && c <= 46);
    ld(20);
    idle_value <= 30;
    idle_load <= 1;
    @(posedge ref_clk);
    idle_load <= 0;
    wt(2, 40, c);
    chk("idle drop", 1, c >= 20 && c <= 33);
    repeat (5) @(posedge ref_clk);
    chk("stays closed", 0, conn_open);
    conn_req <= 1;
    wt(1, 5, c);
    chk("reopened", 1, conn_open);
    chk("eff step", 16'h6666, eff_step);
    end_sim();
  end
endmodule
`default_nettype wire
